// >>> core/hps_pkg.sv
// Package: register map, field positions, reset values, timing counts
// Assumes a 20 MHz pclk and 32-bit APB register access.
package hps_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] HOTPLUG_CONFIG_CONTROL_OFF = 12'h408;
   localparam logic [11:0] SOFTWARE_SCRATCH_OFF       = 12'h40C;
   localparam logic [11:0] SLOT_CONTROL_REG_OFF       = 12'h410;
   localparam logic [11:0] SLOT_STATUS_OFF            = 12'h414;
   localparam logic [31:0] CFG_RESET                  = 32'h1414_0800;
   localparam logic [31:0] CFG_WMASK                  = 32'hFFFF_FFFF;
   localparam logic [31:0] SCRATCH_RESET              = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int INV_ATTN_BUTTON        = 0;
   localparam int INV_PRESENCE_DETECT    = 1;
   localparam int INV_POWER_FAULT        = 2;
   localparam int INV_LATCH_SENSOR       = 3;
   localparam int INV_ATTN_INDICATOR     = 4;
   localparam int INV_POWER_INDICATOR    = 5;
   localparam int INV_POWER_ENABLE       = 6;
   localparam int INV_INTERLOCK_DRIVE    = 7;
   localparam int INV_POWER_GOOD         = 8;
   localparam int LATCH_OPEN_AUTO_OFF    = 11;
   localparam int LATCH_AS_LOCK_STATE    = 12;
   localparam int INTERLOCK_TOGGLE_SEL   = 13;
   localparam int RESET_MODE_LSB         = 14;
   localparam int POWER_TO_RESET_DELAY_LSB            = 16;
   localparam int RESET_TO_POWER_OFF_DELAY_LSB            = 24;
   // Slot control own register fields
   localparam int POWER_CONTROLLER_CTL   = 0;
   localparam int INTERLOCK_COMMAND      = 1;
   localparam int ATTN_IND_CTL           = 2;
   localparam int POWER_IND_CTL          = 3;
   localparam int LATCH_PRESENT_CAP      = 4;
   // ---------------------------------------------------------------
   // Reset modes and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_PEC = 2'h0;
   localparam logic [1:0] MODE_PGC = 2'h1;
   localparam logic [1:0] MODE_HOT = 2'h2;
   localparam int CLK_HZ          = 20_000_000;
   localparam int TICK_MS         = 10;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int PULSE_MS        = 125;
   localparam int PULSE_CYCLES    = CLK_HZ / 1000 * PULSE_MS;
endpackage : hps_pkg

// >>> core/hps_seq.sv
// Hot-plug slot configuration, polarity and power/reset sequencing
// Assumes APB master on pclk; slot pins are asynchronous to pclk.
// Function
// - Invert attention button, presence inputs by bit
// - Invert power fault, latch sensor inputs
// - Invert power good input by bit 8
// - Invert attention, power indicator outputs
// - Invert power enable, interlock outputs
// - Latch open removes power when enabled
// - Auto power-off ignores power controller bit
// - Latch input may report lock state
// - Interlock command pulses output 125 ms
// - Toggle mode flips interlock output per command
// - Mode 0 resets from power enable
// - Mode 1 resets from power good
// - Mode 2 resets from hot reset
// - Power-to-reset delay in 10 ms steps
// - Reset-to-power-off delay in 10 ms steps
// - Zero delay count means no delay
// - Scratch register, no side effects
`timescale 1ns/1ps
module hps_seq #(
   parameter int PORTS        = 2,
   parameter int TICK_CYCLES  = hps_pkg::TICK_CYCLES,
   parameter int PULSE_CYCLES = hps_pkg::PULSE_CYCLES
) (
   // Clock and resets
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             hot_reset,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // Slot sideband pins
   input  wire logic [PORTS-1:0] attn_button_in,
   input  wire logic [PORTS-1:0] presence_detect_in,
   input  wire logic [PORTS-1:0] power_fault_in,
   input  wire logic [PORTS-1:0] latch_sensor_in,
   input  wire logic [PORTS-1:0] slot_power_good_in,
   output logic      [PORTS-1:0] attn_indicator_out,
   output logic      [PORTS-1:0] power_indicator_out,
   output logic      [PORTS-1:0] slot_power_enable_out,
   output logic      [PORTS-1:0] interlock_drive_out,
   output logic      [PORTS-1:0] port_reset_n_out,
   // Conditioned slot state
   output logic      [PORTS-1:0] attn_button,
   output logic      [PORTS-1:0] presence_detect,
   output logic      [PORTS-1:0] power_fault,
   output logic      [PORTS-1:0] latch_open,
   output logic      [PORTS-1:0] lock_engaged
);
   typedef enum logic [1:0] {
      HPS_OFF   = 2'b00,
      HPS_UP    = 2'b01,
      HPS_ON    = 2'b10,
      HPS_DOWN  = 2'b11
   } hps_state_t;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] hotplug_config_control;
   logic [31:0] software_scratch;
   logic [31:0] slot_control_reg;
   logic        wr_en;
   logic        cmd_pulse;

   // Writes land in the access phase only; no wait states are needed
   // because every register answers from flops in a single cycle.
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;

   // Sticky config: only the fundamental reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hotplug_config_control <= hps_pkg::CFG_RESET;
      end else if (wr_en && paddr == hps_pkg::HOTPLUG_CONFIG_CONTROL_OFF) begin
         hotplug_config_control <= pwdata & hps_pkg::CFG_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         software_scratch <= hps_pkg::SCRATCH_RESET;
      end else if (wr_en && paddr == hps_pkg::SOFTWARE_SCRATCH_OFF) begin
         software_scratch <= pwdata;
      end
   end

   // Interlock command bit is write-one action, reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_control_reg <= 32'h0000_0000;
      end else if (hot_reset) begin
         slot_control_reg <= 32'h0000_0000;
      end else if (wr_en && paddr == hps_pkg::SLOT_CONTROL_REG_OFF) begin
         slot_control_reg <= {27'h0, pwdata[4:2], 1'b0, pwdata[0]};
      end
   end

   assign cmd_pulse = wr_en && paddr == hps_pkg::SLOT_CONTROL_REG_OFF &&
                      pwdata[hps_pkg::INTERLOCK_COMMAND];

   logic [1:0] cfg_mode;
   assign cfg_mode = hotplug_config_control[hps_pkg::RESET_MODE_LSB +: 2];

   // ---------------------------------------------------------------
   // Input synchronisers and polarity
   // ---------------------------------------------------------------
   logic [4*PORTS+PORTS-1:0] sync1;
   logic [4*PORTS+PORTS-1:0] sync2;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {slot_power_good_in, latch_sensor_in, power_fault_in,
                   presence_detect_in, attn_button_in};
         sync2 <= sync1;
      end
   end

   logic [PORTS-1:0] power_good;
   logic [PORTS-1:0] latch_raw;
   // Pins are active low unless inverted
   assign attn_button     = ~sync2[0*PORTS +: PORTS] ^
      {PORTS{hotplug_config_control[hps_pkg::INV_ATTN_BUTTON]}};
   assign presence_detect = ~sync2[1*PORTS +: PORTS] ^
      {PORTS{hotplug_config_control[hps_pkg::INV_PRESENCE_DETECT]}};
   assign power_fault     = ~sync2[2*PORTS +: PORTS] ^
      {PORTS{hotplug_config_control[hps_pkg::INV_POWER_FAULT]}};
   // Latch sensor is active low at the pin like the others: high = closed
   assign latch_raw       = ~sync2[3*PORTS +: PORTS] ^
      {PORTS{hotplug_config_control[hps_pkg::INV_LATCH_SENSOR]}};
   assign power_good      = ~sync2[4*PORTS +: PORTS] ^
      {PORTS{hotplug_config_control[hps_pkg::INV_POWER_GOOD]}};

   // Conditioned levels lag the pins by two clocks; software that
   // flips a polarity bit sees the new level at once, not after sync.
   logic lock_mode;
   assign lock_mode    = hotplug_config_control[hps_pkg::LATCH_AS_LOCK_STATE];
   // Either latch status or lock state, never both
   assign latch_open   = lock_mode ? '0 : latch_raw;
   assign lock_engaged = lock_mode ? latch_raw : '0;

   // ---------------------------------------------------------------
   // Per-port sequencer
   // ---------------------------------------------------------------
   logic [PORTS-1:0] pwr_on;
   logic [PORTS-1:0] rst_n;
   logic [PORTS-1:0] ilock;

   for (genvar p = 0; p < PORTS; p++) begin : g_port
      hps_state_t state;
      logic [31:0] tick_cnt;
      logic [7:0]  step_cnt;
      logic [31:0] pulse_cnt;
      logic        want_on;
      logic        auto_off;
      logic        tick;
      logic        stable;

      // Auto power-off overrides the software power bit
      assign auto_off = hotplug_config_control[hps_pkg::LATCH_OPEN_AUTO_OFF]
                     && slot_control_reg[hps_pkg::LATCH_PRESENT_CAP]
                     && latch_open[p];
      assign want_on  = slot_control_reg[hps_pkg::POWER_CONTROLLER_CTL]
                     && !auto_off;
      assign tick     = tick_cnt == 32'(TICK_CYCLES - 1);
      assign stable   = cfg_mode == hps_pkg::MODE_PGC ? power_good[p]
                                                      : 1'b1;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            state    <= HPS_OFF;
            tick_cnt <= '0;
            step_cnt <= '0;
         end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
            if (tick) begin
               step_cnt <= step_cnt + 8'h1;
            end
            case (state)
               HPS_OFF: begin
                  if (want_on) begin
                     state    <= HPS_UP;
                     tick_cnt <= '0;
                     step_cnt <= '0;
                  end
               end
               HPS_UP: begin
                  if (!want_on) begin
                     state <= HPS_OFF;
                  end else if (!stable) begin
                     tick_cnt <= '0;
                     step_cnt <= '0;
                  end else if (step_cnt >= hotplug_config_control[
                           hps_pkg::POWER_TO_RESET_DELAY_LSB +: 8]) begin
                     state <= HPS_ON;
                  end
               end
               HPS_ON: begin
                  if (!want_on) begin
                     state    <= HPS_DOWN;
                     tick_cnt <= '0;
                     step_cnt <= '0;
                  end
               end
               default: begin
                  if (step_cnt >= hotplug_config_control[
                        hps_pkg::RESET_TO_POWER_OFF_DELAY_LSB +: 8]) begin
                     state <= HPS_OFF;
                  end
               end
            endcase
         end
      end

      // Power stays on through the reset-to-off delay so, in every mode but mode 2,
      // the slot sees reset asserted before its supply collapses.
      assign pwr_on[p] = state != HPS_OFF;
      // Reset source chosen by mode; reserved mode behaves as mode 0
      always_comb begin
         if (cfg_mode == hps_pkg::MODE_HOT) begin
            rst_n[p] = !hot_reset && pwr_on[p];
         end else begin
            rst_n[p] = state == HPS_ON;
         end
      end

      // Interlock: pulse or toggle
      // A command during a running pulse restarts the full pulse length.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ilock[p]  <= 1'b0;
            pulse_cnt <= '0;
         end else if (cmd_pulse) begin
            if (hotplug_config_control[hps_pkg::INTERLOCK_TOGGLE_SEL]) begin
               ilock[p] <= !ilock[p];
            end else begin
               ilock[p]  <= 1'b1;
               pulse_cnt <= 32'(PULSE_CYCLES - 1);
            end
         end else if (!hotplug_config_control[
                        hps_pkg::INTERLOCK_TOGGLE_SEL]) begin
            if (pulse_cnt != '0) begin
               pulse_cnt <= pulse_cnt - 32'h1;
            end else begin
               ilock[p] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Output registers, with polarity on all but port reset
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         attn_indicator_out    <= '0;
         power_indicator_out   <= '0;
         slot_power_enable_out <= '0;
         interlock_drive_out   <= '0;
         port_reset_n_out      <= '0;
      end else begin
         attn_indicator_out    <= {PORTS{slot_control_reg[hps_pkg::ATTN_IND_CTL]
            ^ hotplug_config_control[hps_pkg::INV_ATTN_INDICATOR]}};
         power_indicator_out   <= {PORTS{slot_control_reg[hps_pkg::POWER_IND_CTL]
            ^ hotplug_config_control[hps_pkg::INV_POWER_INDICATOR]}};
         slot_power_enable_out <= pwr_on ^
            {PORTS{hotplug_config_control[hps_pkg::INV_POWER_ENABLE]}};
         interlock_drive_out   <= ilock ^
            {PORTS{hotplug_config_control[hps_pkg::INV_INTERLOCK_DRIVE]}};
         port_reset_n_out      <= rst_n;
      end
   end

   // ---------------------------------------------------------------
   // Read path, captured in setup phase
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         if (paddr == hps_pkg::HOTPLUG_CONFIG_CONTROL_OFF) begin
            prdata <= hotplug_config_control;
         end else if (paddr == hps_pkg::SOFTWARE_SCRATCH_OFF) begin
            prdata <= software_scratch;
         end else if (paddr == hps_pkg::SLOT_CONTROL_REG_OFF) begin
            prdata <= slot_control_reg;
         end else if (paddr == hps_pkg::SLOT_STATUS_OFF) begin
            prdata <= 32'(rst_n) << 16 | 32'(pwr_on);
         end else begin
            prdata  <= '0;
            pslverr <= 1'b1;
         end
      end
   end

endmodule : hps_seq

// >>> verif/hps_seq_checker.sv
// Checker: bus, polarity and sequencing relations of the slot block
// Assumes bind to hps_seq; word writes with no wait states.
`timescale 1ns/1ps
module hps_seq_checker #(
   parameter int PORTS = 2
) (
   // Clock, resets and bus
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             hot_reset,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   // Slot pins and conditioned state
   input wire logic [PORTS-1:0] attn_button_in,
   input wire logic [PORTS-1:0] latch_sensor_in,
   input wire logic [PORTS-1:0] attn_indicator_out,
   input wire logic [PORTS-1:0] slot_power_enable_out,
   input wire logic [PORTS-1:0] port_reset_n_out,
   input wire logic [PORTS-1:0] attn_button,
   input wire logic [PORTS-1:0] latch_open
);
   // ------------------------------------------
   // Register shadows, updated like the design's
   // ------------------------------------------
   logic [31:0] cfg;
   logic [4:0]  sctl;
   logic [1:0]  warm;
   logic        wr;
   logic        mapped;
   assign wr = psel & penable & pwrite;
   assign mapped = paddr inside {12'h408, 12'h40C, 12'h410, 12'h414};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg  <= hps_pkg::CFG_RESET;
         warm <= 2'h0;
      end else begin
         if (warm != 2'h3)
            warm <= warm + 2'h1;
         if (wr && paddr == 12'h408)
            cfg <= pwdata;
      end
   end
   // Hot reset clears only the slot control shadow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sctl <= 5'h00;
      else if (hot_reset)
         sctl <= 5'h00;
      else if (wr && paddr == 12'h410)
         sctl <= pwdata[4:0];
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   pready_high_a: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   decode_err_a: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr disagrees with the map");
   unmapped_zero_a: assert property (
      psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read gave data");
   button_sync_a: assert property (warm == 2'h3 |->
      attn_button == ~($past(attn_button_in, 2) ^ {PORTS{cfg[0]}}))
      else $error("button level wrong");
   latch_sync_a: assert property (warm == 2'h3 |->
      latch_open == (cfg[12] ? '0 :
      ~($past(latch_sensor_in, 2) ^ {PORTS{cfg[3]}})))
      else $error("latch level wrong");
   indicator_pol_a: assert property (warm == 2'h3 |->
      attn_indicator_out == {PORTS{$past(sctl[2] ^ cfg[4])}})
      else $error("attention indicator wrong");
   reset_power_a: assert property (
      port_reset_n_out[0] |-> slot_power_enable_out[0] != $past(cfg[6]))
      else $error("port reset released unpowered");
   hot_mode_a: assert property (
      cfg[15:14] == hps_pkg::MODE_HOT && hot_reset |-> ##[1:2]
      !port_reset_n_out[0])
      else $error("hot reset left port reset high");
   auto_off_a: assert property (
      latch_open[0] && cfg[11] && sctl[4] && !cfg[12] |-> ##[1:600]
      slot_power_enable_out[0] == cfg[6])
      else $error("open latch kept slot power");
endmodule : hps_seq_checker

// >>> verif/hps_seq_tb.sv
// Testbench: registers, pin polarity and power/reset sequencing
// Assumes shortened tick and pulse counts on the instance below.
`timescale 1ns/1ps
module hps_seq_tb;
   localparam int T  = 10;
   localparam int PL = 50;
   localparam int PG = 40;
   localparam logic [11:0] CFG = hps_pkg::HOTPLUG_CONFIG_CONTROL_OFF;
   localparam logic [11:0] SCR = hps_pkg::SOFTWARE_SCRATCH_OFF;
   localparam logic [11:0] SCT = hps_pkg::SLOT_CONTROL_REG_OFF;
   logic        pclk, presetn, hot_reset, psel, penable, pwrite, pg_inv;
   logic        pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, x, y;
   logic [1:0]  attn_button_in, presence_detect_in, power_fault_in;
   logic [1:0]  latch_sensor_in, slot_power_good_in, attn_indicator_out;
   logic [1:0]  power_indicator_out, slot_power_enable_out;
   logic [1:0]  interlock_drive_out, port_reset_n_out, attn_button;
   logic [1:0]  presence_detect, power_fault, latch_open, lock_engaged;
   int          n_mismatch = 0, compares = 0, cyc = 0, seed, n;
   hps_seq #(.PORTS(2), .TICK_CYCLES(T), .PULSE_CYCLES(PL)) dut (.*);
   hps_slot_model #(.PORTS(2), .PG_DLY(PG)) slot (
      .pclk         (pclk),
      .power_on     (slot_power_enable_out),
      .inv_pg       (pg_inv),
      .power_good_n (slot_power_good_in)
   );
   // ------------------------------------------
   // Expectations, bus cycles and waits
   // ------------------------------------------
   function automatic logic [1:0] cond(input logic [1:0] p, input logic v);
      return ~(p ^ {2{v}});
   endfunction : cond
   function automatic logic pick(input int s);
      case (s)
         0: return port_reset_n_out[0];
         1: return slot_power_enable_out[0];
         default: return interlock_drive_out[0];
      endcase
   endfunction : pick
   task automatic chk(input logic [31:0] g, input logic [31:0] x_, string m);
      compares++;
      if (g !== x_) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic chk2(input logic [1:0] g, input logic [1:0] x_, string m);
      chk({30'h0, g}, {30'h0, x_}, m);
   endtask : chk2
   task automatic okay(input logic c, input string m);
      chk({31'h0, c}, 32'h1, m);
   endtask : okay
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask : wr
   task automatic wait_on(input int s, input logic v, output int k);
      k = 0;
      while (pick(s) !== v && k < 2000) begin
         @(posedge pclk);
         k++;
      end
   endtask : wait_on
   task automatic stop_test();
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      seed = 51565;
      {psel, penable, pwrite, hot_reset, pg_inv} <= 5'h00;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      {attn_button_in, presence_detect_in, power_fault_in} <= 6'h3F;
      latch_sensor_in <= 2'h3;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CFG, 32'h0, r, e);
      chk(r, hps_pkg::CFG_RESET, "config reset");
      apb(1'b0, SCR, 32'h0, r, e);
      chk(r, hps_pkg::SCRATCH_RESET, "scratch reset");
      repeat (3) begin
         x = $random(seed);
         wr(SCR, x);
         apb(1'b0, SCR, 32'h0, r, e);
         chk(r, x, "scratch readback");
      end
      apb(1'b0, 12'h400, 32'h0, r, e);
      okay(e === 1'b1 && r === 32'h0, "unmapped access");
      repeat (6) begin
         x = $random(seed) & 32'h0000_11FF;
         y = $random(seed);
         wr(CFG, x);
         wr(SCT, y & 32'h0000_000C);
         attn_button_in     <= y[17:16];
         presence_detect_in <= y[19:18];
         power_fault_in     <= y[21:20];
         latch_sensor_in    <= y[23:22];
         repeat (3) @(posedge pclk);
         #1;
         chk2(attn_button, cond(y[17:16], x[0]), "button");
         chk2(presence_detect, cond(y[19:18], x[1]), "presence");
         chk2(power_fault, cond(y[21:20], x[2]), "fault");
         chk2(latch_open, x[12] ? 2'h0 : cond(y[23:22], x[3]), "latch");
         chk2(lock_engaged, x[12] ? cond(y[23:22], x[3]) : 2'h0, "lock");
         chk2(attn_indicator_out, {2{y[2] ^ x[4]}}, "attn ind");
         chk2(power_indicator_out, {2{y[3] ^ x[5]}}, "power ind");
         chk2(slot_power_enable_out, {2{x[6]}}, "enable idle");
         chk2(interlock_drive_out, {2{x[7]}}, "interlock idle");
      end
      latch_sensor_in <= 2'h3;
      wr(CFG, 32'h0203_0040);
      wr(SCT, 32'h1);
      wait_on(0, 1'b1, n);
      okay(n >= 3 * T && n <= 4 * T + 5, "power to reset");
      chk2(slot_power_enable_out, 2'h0, "inverted enable");
      wr(SCT, 32'h0);
      wait_on(0, 1'b0, n);
      wait_on(1, 1'b1, n);
      okay(n >= 2 * T - 3 && n <= 3 * T + 5, "reset to off");
      wr(CFG, 32'h0);
      wr(SCT, 32'h1);
      wait_on(0, 1'b1, n);
      okay(n <= 5, "zero power to reset");
      wr(SCT, 32'h0);
      wait_on(1, 1'b0, n);
      okay(n <= 5, "zero reset to off");
      pg_inv <= 1'b1;
      wr(CFG, 32'h0001_4100);
      wr(SCT, 32'h1);
      wait_on(0, 1'b1, n);
      okay(n >= PG + T && n <= PG + 2 * T + 5, "power good wait");
      wr(SCT, 32'h0);
      wait_on(1, 1'b0, n);
      wr(CFG, 32'h0000_8000);
      wr(SCT, 32'h1);
      wait_on(0, 1'b1, n);
      okay(n <= 8, "hot mode release");
      hot_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      chk2(port_reset_n_out, 2'h0, "hot reset held");
      @(posedge pclk);
      hot_reset <= 1'b0;
      apb(1'b0, CFG, 32'h0, r, e);
      chk(r, 32'h0000_8000, "config kept");
      apb(1'b0, SCT, 32'h0, r, e);
      chk(r, 32'h0, "slot control cleared");
      wr(CFG, 32'h0);
      wr(SCT, 32'h2);
      wait_on(2, 1'b1, n);
      wait_on(2, 1'b0, n);
      okay(n >= PL - 3 && n <= PL + 3, "pulse length");
      wr(CFG, 32'h0000_2080);
      for (int i = 0; i < 2; i++) begin
         wr(SCT, 32'h2);
         repeat (3) @(posedge pclk);
         #1;
         chk2(interlock_drive_out, {2{i[0]}}, "toggle");
      end
      wr(CFG, 32'h0000_0800);
      wr(SCT, 32'h11);
      wait_on(1, 1'b1, n);
      latch_sensor_in <= 2'h0;
      wait_on(1, 1'b0, n);
      okay(n <= 12, "open latch power off");
      apb(1'b0, SCT, 32'h0, r, e);
      chk(r & 32'h1F, 32'h11, "control bit kept");
      stop_test();
   end
endmodule : hps_seq_tb
bind hps_seq hps_seq_checker #(.PORTS(PORTS)) chk (.*);

// >>> verif/hps_slot_model.sv
// Partner: slot supply that reports power good after a ramp
// Assumes power enable is sensed active high at the block's pins.
`timescale 1ns/1ps
module hps_slot_model #(
   parameter int PORTS  = 2,
   parameter int PG_DLY = 40
) (
   // Clock and supply control
   input  wire logic             pclk,
   input  wire logic [PORTS-1:0] power_on,
   input  wire logic             inv_pg,
   // Power good, active low unless inverted
   output logic      [PORTS-1:0] power_good_n
);
   // ------------------------------------------
   // Ramp: good drops at once when power goes
   // ------------------------------------------
   int cnt [PORTS] = '{default: 0};
   always @(posedge pclk)
      for (int i = 0; i < PORTS; i++)
         cnt[i] <= !power_on[i] ? 0 : (cnt[i] == PG_DLY ? PG_DLY : cnt[i] + 1);
   always_comb
      for (int i = 0; i < PORTS; i++)
         power_good_n[i] = (cnt[i] == PG_DLY) ~^ inv_pg;
endmodule : hps_slot_model
